// File: shared/bfb_regs.svh
// Purpose: constants of the burst flash bus interface
// Assumes: word addressing, 16-bit data, 100 MHz core clock
// Notes: plain defines, no logic
// Behaviour
// [RULE_01] Array splits into equal 64-Kword erase blocks
// [RULE_02] Block is 512 rows, 16 eight-word groups
// [RULE_03] Page reads 8 words, bursts 8 or 16; code fetches one word (BFB_ASYNC_WORDS) per async read
// [RULE_04] Address captured on reads and on writes
// [RULE_05] Data bus floats unless selected and read-enabled
// [RULE_06] Deselect floats data and wait outputs
// [RULE_07] Data drivers on only while output enable low
// [RULE_08] Address and data taken at write strobe rise
// [RULE_09] Device reset low clears logic, refuses writes
// [RULE_10] Reset exit gives asynchronous array reads
// [RULE_11] Guard low: locked-down blocks ignore unlock
// [RULE_12] Guard high overrides lock-down for program, erase
// [RULE_13] Sync address latched at first strobe rise or edge
// [RULE_14] Bus clock steps burst address and output data
// [RULE_15] Unused bus clock is tied high by board
// [RULE_16] Permit low rejects every program and erase
// [RULE_17] Status flag defaults to level ready/busy mode
// [RULE_18] Pulse modes flag program and/or erase completion
// [RULE_19] Wait flags burst cycles without valid data
// [RULE_20] Wait floats when deselected, ignores output enable
// [RULE_21] Read configuration governs every following burst
`ifndef BFB_REGS_SVH
`define BFB_REGS_SVH
`define BFB_ADDR_W 24
`define BFB_BLOCK_AW 16
`define BFB_ROW_LSB 7
`define BFB_GROUP_LSB 3
`define BFB_CMD_READ_ARRAY 8'hFF
`define BFB_CMD_READ_STATUS 8'h70
`define BFB_CMD_CLEAR_STATUS 8'h50
`define BFB_CMD_CFG_SETUP 8'h60
`define BFB_CMD_CFG_RCR 8'h03
`define BFB_CMD_LOCK 8'h01
`define BFB_CMD_UNLOCK 8'hD0
`define BFB_CMD_LOCKDOWN 8'h2F
`define BFB_CMD_PROGRAM 8'h40
`define BFB_CMD_ERASE 8'h20
`define BFB_CMD_CONFIRM 8'hD0
`define BFB_CMD_STS_CFG 8'hB8
`define BFB_RCR_RESET 16'h9042
`define BFB_RCR_ASYNC 15
`define BFB_RCR_LAT_MSB 13
`define BFB_RCR_LAT_LSB 11
`define BFB_RCR_WAIT_POL 10
`define BFB_RCR_CLK_RISE 6
`define BFB_RCR_LEN16 3'h3
`define BFB_WRAP_MASK_8 4'h7
`define BFB_WRAP_MASK_16 4'hF
`define BFB_BURST_SHORT 5'h08
`define BFB_BURST_LONG 5'h10
`define BFB_ASYNC_WORDS 5'h01
`define BFB_SR_READY 7
`define BFB_SR_PERMIT_ERR 3
`define BFB_SR_LOCK_ERR 1
`define BFB_CLK_PERIOD_NS 10
`define BFB_STS_PULSE_NS 250
`define BFB_STS_PULSE_CYC \
  ((`BFB_STS_PULSE_NS + `BFB_CLK_PERIOD_NS - 1) / `BFB_CLK_PERIOD_NS)
`endif

// File: shared/bfb_pkg.sv
// Purpose: types of the burst flash bus interface
// Assumes: constants come from bfb_regs.svh
// Notes: one-hot state codes; status mode codes are binary
package bfb_pkg;
  typedef enum logic [2:0] {BFB_ST_IDLE = 3'h1, BFB_ST_LAT = 3'h2,
    BFB_ST_BURST = 3'h4} bfb_burst_state_t;
  typedef enum logic [4:0] {BFB_PD_NONE = 5'h01, BFB_PD_CFG = 5'h02,
    BFB_PD_PROG = 5'h04, BFB_PD_ERASE = 5'h08,
    BFB_PD_STS = 5'h10} bfb_pend_t;
  typedef enum logic [1:0] {BFB_SRC_ARRAY = 2'h1,
    BFB_SRC_STATUS = 2'h2} bfb_src_t;
  typedef enum logic [1:0] {BFB_STS_LEVEL = 2'h0, BFB_STS_ERASE = 2'h1,
    BFB_STS_PROG = 2'h2, BFB_STS_BOTH = 2'h3} bfb_sts_mode_t;
endpackage : bfb_pkg

// File: shared/bfb_word_if.sv
// Purpose: valid/ready word carrier between internal modules
// Assumes: single clock
// Notes: src drives valid and data, snk drives ready
`timescale 1ns/100ps
interface bfb_word_if #(parameter int W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bfb_word_if

// File: verilog/bfb_pair_buf.sv
// Purpose: small FIFO between array answers and the output stage
// Assumes: DEPTH is a power of two
// Notes: flush drops contents and any push in the same cycle
`timescale 1ns/100ps
`include "bfb_regs.svh"
module bfb_pair_buf #(parameter int W = 16, parameter int DEPTH = 2) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic flush,
  bfb_word_if.snk inp,
  bfb_word_if.src outp
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0] cnt;
  wire push = inp.valid && inp.ready;
  wire pop = outp.valid && outp.ready;
  assign inp.ready = cnt != (PW+1)'(DEPTH);
  assign outp.valid = cnt != '0;
  assign outp.data = mem[rp];
  always_ff @(posedge clock) begin
    if (push) mem[wp] <= inp.data;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else if (flush) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  chk_buf_bound: assert property (@(posedge clock) disable iff (!nrst)
    cnt <= (PW+1)'(DEPTH)) else $error("buffer overfilled");
  chk_buf_keep: assert property (@(posedge clock) disable iff (!nrst)
    push && !pop && !flush |=> outp.valid) else $error("push lost");
endmodule : bfb_pair_buf

// File: verilog/bfb_burst_ctr.sv
// Purpose: burst address generator with 8 or 16 word wrap
// Assumes: a burst may start on any word and wraps inside its own length
// Notes: upper address bits never change inside a burst
`timescale 1ns/100ps
`include "bfb_regs.svh"
module bfb_burst_ctr #(parameter int ADDR_W = `BFB_ADDR_W) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic load,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic inc,
  input wire logic len16,
  output logic [ADDR_W-1:0] addr
);
  logic [3:0] mask;
  logic [3:0] low_next;
  assign mask = len16 ? `BFB_WRAP_MASK_16 : `BFB_WRAP_MASK_8;
  assign low_next = ((addr[3:0] + 4'h1) & mask) | (addr[3:0] & ~mask);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) addr <= '0;
    else if (load) addr <= load_addr;
    else if (inc) addr <= {addr[ADDR_W-1:4], low_next}; // RULE_14
  end
  chk_wrap_group: assert property (@(posedge clock) disable iff (!nrst) // RULE_14
    inc && !load |=> addr[ADDR_W-1:4] == $past(addr[ADDR_W-1:4]))
    else $error("burst address left its group");
endmodule : bfb_burst_ctr

// File: verilog/bfb_flash_if.sv
// Purpose: bus interface of a parallel burst NOR flash
// Assumes: all pins sampled on clock; array and write engine outside
// Notes: open-drain flag pulls low while state_machine_flag_oe is high
`timescale 1ns/100ps
`include "bfb_regs.svh"
module bfb_flash_if
  import bfb_pkg::*;
#(
  parameter int ADDR_W = `BFB_ADDR_W,
  parameter int LAT_W = 3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic device_reset_n,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic addr_valid_strobe_n,
  input wire logic bus_clk,
  input wire logic lockdown_guard_n,
  input wire logic program_erase_permit,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic wait_out,
  output logic wait_oe,
  output logic state_machine_flag_oe,
  output logic arr_req,
  output logic [ADDR_W-1:0] arr_addr,
  input wire logic arr_ack,
  input wire logic [15:0] arr_data,
  output logic pe_req,
  output logic pe_erase,
  output logic [ADDR_W-1:0] pe_addr,
  output logic [15:0] pe_data,
  input wire logic wsm_busy,
  input wire logic wsm_prog_done,
  input wire logic wsm_erase_done
);
  localparam int BLK_W = ADDR_W - `BFB_BLOCK_AW;
  localparam int NUM_BLOCKS = 1 << BLK_W;

  logic we_q;
  logic adv_q;
  logic bclk_q;
  logic lat_done;
  logic [ADDR_W-1:0] lat_addr;
  logic [15:0] rcr;
  bfb_src_t rd_src;
  bfb_pend_t pend;
  bfb_sts_mode_t sts_mode;
  logic permit_err;
  logic lock_err;
  logic locked [NUM_BLOCKS];
  logic down [NUM_BLOCKS];
  bfb_burst_state_t state;
  logic [LAT_W-1:0] lat_cnt;
  logic [4:0] fetch_left;
  logic [4:0] out_left;
  logic outstanding;
  logic drop;
  logic word_ok;
  logic [7:0] pulse_cnt;
  logic [ADDR_W-1:0] fetch_addr;

  // Decode of the sampled pins
  wire [7:0] cmd = data_in[7:0];
  wire sync_mode = !rcr[`BFB_RCR_ASYNC];
  wire len16 = rcr[2:0] == `BFB_RCR_LEN16;
  wire [4:0] burst_words = len16 ? `BFB_BURST_LONG : `BFB_BURST_SHORT; // RULE_03
  wire we_rise = !we_q && write_strobe_n && !chip_enable_n
    && device_reset_n; // RULE_08 RULE_09
  wire cfg_wr = we_rise && pend == BFB_PD_CFG;
  wire [BLK_W-1:0] cur_blk = addr[ADDR_W-1:`BFB_BLOCK_AW]; // RULE_01
  // Row field is for reference; 8-word bursts wrap inside a group, 16-word bursts inside two
  wire [8:0] cur_row = addr[`BFB_BLOCK_AW-1:`BFB_ROW_LSB]; // RULE_02
  wire pe_blocked = locked[cur_blk]
    && !(down[cur_blk] && lockdown_guard_n); // RULE_12
  wire pe_ok = program_erase_permit && !pe_blocked && !wsm_busy; // RULE_16
  // A board that ties the clock high simply never produces an edge
  wire bclk_edge = rcr[`BFB_RCR_CLK_RISE] ? (bus_clk && !bclk_q)
    : (!bus_clk && bclk_q); // RULE_15
  wire adv_low = !addr_valid_strobe_n && !chip_enable_n;
  wire adv_rise = !adv_q && addr_valid_strobe_n && !chip_enable_n;
  wire sync_start = sync_mode && !lat_done
    && ((adv_low && bclk_edge) || adv_rise); // RULE_13
  wire async_start = !sync_mode && !chip_enable_n && write_strobe_n
    && (!lat_done || (adv_low && addr != lat_addr)); // RULE_04 RULE_03
  wire start = device_reset_n && (sync_start || async_start);
  wire issue;
  wire pop;
  wire inval = state == BFB_ST_LAT
    || (state == BFB_ST_BURST && !word_ok); // RULE_19
  wire done_ev = (wsm_prog_done
      && (sts_mode == BFB_STS_PROG || sts_mode == BFB_STS_BOTH))
    || (wsm_erase_done
      && (sts_mode == BFB_STS_ERASE || sts_mode == BFB_STS_BOTH));
  wire [15:0] status_word = (16'(!wsm_busy) << `BFB_SR_READY)
    | (16'(permit_err) << `BFB_SR_PERMIT_ERR)
    | (16'(lock_err) << `BFB_SR_LOCK_ERR);

  bfb_word_if #(.W(16)) fill_if ();
  bfb_word_if #(.W(16)) drain_if ();
  // A stalled output stage holds the buffer full, which stops issue
  assign fill_if.valid = arr_ack && !drop;
  assign fill_if.data = arr_data;
  assign drain_if.ready = pop;
  assign pop = drain_if.valid && rd_src == BFB_SRC_ARRAY
    && (sync_mode ? (state == BFB_ST_BURST && bclk_edge) : 1'b1); // RULE_14
  assign issue = fetch_left != 5'h00 && !outstanding && fill_if.ready
    && !start;

  bfb_pair_buf #(.W(16), .DEPTH(2)) u_buf (
    .clock(clock),
    .nrst(nrst),
    .flush(start),
    .inp(fill_if),
    .outp(drain_if)
  );

  bfb_burst_ctr #(.ADDR_W(ADDR_W)) u_ctr (
    .clock(clock),
    .nrst(nrst),
    .load(start),
    .load_addr(addr),
    .inc(issue),
    .len16(len16),
    .addr(fetch_addr)
  );

  // Pin history for edge detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      we_q <= 1'b1;
      adv_q <= 1'b1;
      bclk_q <= 1'b1;
    end else begin
      we_q <= write_strobe_n;
      adv_q <= addr_valid_strobe_n;
      bclk_q <= bus_clk;
    end
  end

  // Read address latch, frozen until the next strobe or deselect, or an async address change under a low strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lat_addr <= '0;
      lat_done <= 1'b0;
    end else if (start) begin
      lat_addr <= addr; // RULE_04 RULE_13
      lat_done <= 1'b1;
    end else if (chip_enable_n || !device_reset_n || (adv_q && adv_low)) begin
      lat_done <= 1'b0;
    end
  end

  // Array fetch: one request in flight, stale answers dropped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fetch_left <= 5'h00;
      outstanding <= 1'b0;
      drop <= 1'b0;
      arr_req <= 1'b0;
      arr_addr <= '0;
    end else begin
      arr_req <= 1'b0;
      if (arr_ack) begin
        outstanding <= 1'b0;
        drop <= 1'b0;
      end
      if (!device_reset_n) begin
        fetch_left <= 5'h00;
      end else if (start) begin
        fetch_left <= sync_mode ? burst_words : `BFB_ASYNC_WORDS; // RULE_21
        drop <= outstanding && !arr_ack;
      end else if (issue) begin
        fetch_left <= fetch_left - 5'h01;
        outstanding <= 1'b1;
        arr_req <= 1'b1;
        arr_addr <= fetch_addr;
      end
    end
  end

  // Burst sequencing: latency, then one word per active edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= BFB_ST_IDLE;
      lat_cnt <= '0;
      out_left <= 5'h00;
      word_ok <= 1'b0;
    end else if (!device_reset_n) begin
      state <= BFB_ST_IDLE;
      word_ok <= 1'b0;
    end else if (start && sync_mode) begin
      state <= BFB_ST_LAT;
      lat_cnt <= LAT_W'(rcr[`BFB_RCR_LAT_MSB:`BFB_RCR_LAT_LSB]); // RULE_21
      out_left <= burst_words;
      word_ok <= 1'b0;
    end else if (chip_enable_n) begin
      state <= BFB_ST_IDLE;
      word_ok <= 1'b0;
    end else begin
      case (state)
        BFB_ST_IDLE: begin
          word_ok <= 1'b0;
        end
        BFB_ST_LAT: begin
          if (bclk_edge) begin
            if (lat_cnt <= LAT_W'(1)) state <= BFB_ST_BURST;
            else lat_cnt <= lat_cnt - LAT_W'(1);
          end
        end
        BFB_ST_BURST: begin
          if (bclk_edge) begin
            word_ok <= pop; // RULE_19
            if (pop) begin
              out_left <= out_left - 5'h01;
              if (out_left == 5'h01) state <= BFB_ST_IDLE;
            end
          end
        end
        default: state <= BFB_ST_IDLE;
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      wait_out <= 1'b0;
      wait_oe <= 1'b0;
    end else begin
      if (pop) data_out <= drain_if.data;
      else if (rd_src == BFB_SRC_STATUS) data_out <= status_word;
      data_oe <= !chip_enable_n && !output_enable_n && write_strobe_n
        && device_reset_n; // RULE_05 RULE_06 RULE_07
      wait_oe <= !chip_enable_n; // RULE_06 RULE_20
      wait_out <= rcr[`BFB_RCR_WAIT_POL] ? inval : !inval; // RULE_19
    end
  end

  // Command decode on write strobe rise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rcr <= `BFB_RCR_RESET;
      rd_src <= BFB_SRC_ARRAY;
      pend <= BFB_PD_NONE;
      sts_mode <= BFB_STS_LEVEL;
      permit_err <= 1'b0;
      lock_err <= 1'b0;
      pe_req <= 1'b0;
      pe_erase <= 1'b0;
      pe_addr <= '0;
      pe_data <= 16'h0000;
    end else if (!device_reset_n) begin
      rcr <= `BFB_RCR_RESET; // RULE_10
      rd_src <= BFB_SRC_ARRAY; // RULE_10
      pend <= BFB_PD_NONE;
      sts_mode <= BFB_STS_LEVEL; // RULE_17
      permit_err <= 1'b0;
      lock_err <= 1'b0;
      pe_req <= 1'b0; // RULE_09
    end else begin
      pe_req <= 1'b0;
      if (we_rise) begin
        pend <= BFB_PD_NONE;
        case (pend)
          BFB_PD_NONE: begin
            case (cmd)
              `BFB_CMD_READ_ARRAY: rd_src <= BFB_SRC_ARRAY;
              `BFB_CMD_READ_STATUS: rd_src <= BFB_SRC_STATUS;
              `BFB_CMD_CLEAR_STATUS: begin
                permit_err <= 1'b0;
                lock_err <= 1'b0;
              end
              `BFB_CMD_CFG_SETUP: pend <= BFB_PD_CFG;
              `BFB_CMD_PROGRAM: pend <= BFB_PD_PROG;
              `BFB_CMD_ERASE: pend <= BFB_PD_ERASE;
              `BFB_CMD_STS_CFG: pend <= BFB_PD_STS;
              default: rd_src <= rd_src;
            endcase
          end
          BFB_PD_CFG: begin
            if (cmd == `BFB_CMD_CFG_RCR) rcr <= addr[15:0]; // RULE_21
          end
          BFB_PD_PROG, BFB_PD_ERASE: begin
            rd_src <= BFB_SRC_STATUS;
            if (pend == BFB_PD_PROG || cmd == `BFB_CMD_CONFIRM) begin
              if (pe_ok) begin
                pe_req <= 1'b1; // RULE_08 RULE_16
                pe_erase <= pend == BFB_PD_ERASE;
                pe_addr <= addr; // RULE_04
                pe_data <= data_in;
              end else if (!program_erase_permit) begin
                permit_err <= 1'b1; // RULE_16
              end else if (pe_blocked) begin
                lock_err <= 1'b1;
              end
            end
          end
          BFB_PD_STS: sts_mode <= bfb_sts_mode_t'(data_in[1:0]); // RULE_18
          default: pend <= BFB_PD_NONE;
        endcase
      end
    end
  end

  // Per-block lock state; blocks come up locked
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        locked[b] <= 1'b1;
        down[b] <= 1'b0;
      end else if (!device_reset_n) begin
        locked[b] <= 1'b1;
        down[b] <= 1'b0;
      end else if (cfg_wr && cur_blk == BLK_W'(b)) begin
        case (cmd)
          `BFB_CMD_LOCK: locked[b] <= 1'b1;
          `BFB_CMD_LOCKDOWN: begin
            locked[b] <= 1'b1;
            down[b] <= 1'b1;
          end
          `BFB_CMD_UNLOCK: begin
            if (!(down[b] && !lockdown_guard_n)) locked[b] <= 1'b0; // RULE_11
          end
          default: locked[b] <= locked[b];
        endcase
      end
    end
  end

  // Status flag: level busy, or a fixed pulse on completion
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt <= 8'h00;
      state_machine_flag_oe <= 1'b0;
    end else begin
      if (done_ev) pulse_cnt <= 8'(`BFB_STS_PULSE_CYC); // RULE_18
      else if (pulse_cnt != 8'h00) pulse_cnt <= pulse_cnt - 8'h01;
      state_machine_flag_oe <= (sts_mode == BFB_STS_LEVEL) ? wsm_busy
        : (pulse_cnt != 8'h00); // RULE_17 RULE_18
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_data_float_ce: assert property (chip_enable_n |=> !data_oe) // RULE_06
    else $error("data driven while deselected");
  chk_data_float_oe: assert property (output_enable_n |=> !data_oe) // RULE_07
    else $error("data driven with output enable high");
  chk_data_drive: assert property (!chip_enable_n && !output_enable_n // RULE_05
    && write_strobe_n && device_reset_n |=> data_oe)
    else $error("data not driven in read");
  chk_wait_float: assert property (chip_enable_n |=> !wait_oe) // RULE_20
    else $error("wait driven while deselected");
  chk_wait_no_oe: assert property (!chip_enable_n && output_enable_n // RULE_20
    |=> wait_oe) else $error("wait gated by output enable");
  chk_reset_refuse: assert property (!device_reset_n |=> !pe_req) // RULE_09
    else $error("write accepted in reset");
  chk_reset_async: assert property (!device_reset_n |=> // RULE_10
    rcr == `BFB_RCR_RESET && rd_src == BFB_SRC_ARRAY && !sync_mode)
    else $error("reset exit not async array read");
  chk_write_capture: assert property (we_rise && pend == BFB_PD_PROG // RULE_08
    && pe_ok |=> pe_req && pe_data == $past(data_in)
    && pe_addr == $past(addr)) else $error("write not captured");
  chk_permit_gate: assert property (we_rise && !program_erase_permit // RULE_16
    |=> !pe_req ##1 !pe_req) else $error("program without permit");
  chk_unlock_held: assert property (cfg_wr && cmd == `BFB_CMD_UNLOCK // RULE_11
    && down[cur_blk] && !lockdown_guard_n |=> locked[$past(cur_blk)])
    else $error("locked-down block unlocked");
  chk_sync_latch: assert property (start |=> lat_addr == $past(addr)) // RULE_13
    else $error("address not latched");
  chk_lat_wait: assert property (state == BFB_ST_LAT // RULE_19
    |=> wait_out == $past(rcr[`BFB_RCR_WAIT_POL]))
    else $error("wait not flagged in latency");
  chk_flag_level: assert property (sts_mode == BFB_STS_LEVEL // RULE_17
    |=> state_machine_flag_oe == $past(wsm_busy))
    else $error("level flag wrong");
  chk_flag_pulse: assert property (done_ev |=> ##1 state_machine_flag_oe) // RULE_18
    else $error("completion pulse missing");
  cov_burst_done: cover property (state == BFB_ST_BURST
    ##1 state == BFB_ST_IDLE);
  cov_async_read: cover property (!sync_mode && pop && data_oe);
  cov_erase_req: cover property (pe_req && pe_erase);
  cov_pulse: cover property (done_ev ##2 state_machine_flag_oe);
endmodule : bfb_flash_if

// File: tb/bfb_far_model.sv
// Purpose: array and write engine model behind the bus interface
// Assumes: one read outstanding; a new request replaces it
// Notes: idle arr_data toggles so stale words never look valid
`timescale 1ns/100ps
module bfb_far_model #(parameter int ADDR_W = 24) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow,
  input wire logic arr_req,
  input wire logic [ADDR_W-1:0] arr_addr,
  output logic arr_ack,
  output logic [15:0] arr_data,
  input wire logic pe_req,
  input wire logic pe_erase,
  output logic wsm_busy,
  output logic wsm_prog_done,
  output logic wsm_erase_done
);
  logic [3:0] rd_cnt;
  logic [3:0] wr_cnt;
  logic [15:0] word;
  logic ers;
  assign wsm_busy = (wr_cnt != 4'h0);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_cnt <= 4'h0;
      arr_ack <= 1'b0;
      arr_data <= 16'h0000;
      word <= 16'h0000;
    end else begin
      arr_ack <= (rd_cnt == 4'h1) && !arr_req;
      arr_data <= (rd_cnt == 4'h1) ? word : ~arr_data;
      if (arr_req) begin
        rd_cnt <= slow ? 4'h6 : 4'h1;
        word <= arr_addr[15:0] ^ 16'h5A3C;
      end else if (rd_cnt != 4'h0) begin
        rd_cnt <= rd_cnt - 4'h1;
      end
    end
  end
  // Busy for eight cycles, then one done pulse of the right kind
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_cnt <= 4'h0;
      ers <= 1'b0;
      wsm_prog_done <= 1'b0;
      wsm_erase_done <= 1'b0;
    end else begin
      wsm_prog_done <= (wr_cnt == 4'h1) && !ers;
      wsm_erase_done <= (wr_cnt == 4'h1) && ers;
      if (pe_req && !wsm_busy) begin
        wr_cnt <= 4'h8;
        ers <= pe_erase;
      end else if (wr_cnt != 4'h0) begin
        wr_cnt <= wr_cnt - 4'h1;
      end
    end
  end
endmodule : bfb_far_model

// File: tb/testbench.sv
// Purpose: self-checking bench for the flash bus interface
// Assumes: inputs change on falling clock edges
// Notes: array word is address xor 5A3C, made by the far model
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("Error at %0t: got %h exp %h", $time, g, e); \
  end end
module testbench;
  logic clock, nrst, device_reset_n, chip_enable_n, output_enable_n;
  logic write_strobe_n, addr_valid_strobe_n, bus_clk, lockdown_guard_n;
  logic program_erase_permit, slow, data_oe, wait_out, wait_oe, f;
  logic state_machine_flag_oe, arr_req, arr_ack, pe_req, pe_erase, pe_e;
  logic wsm_busy, wsm_prog_done, wsm_erase_done;
  logic [23:0] addr, arr_addr, pe_addr, pe_a;
  logic [15:0] data_in, data_out, arr_data, pe_data, pe_d;
  logic [15:0] q[$];
  int err_total, comparisons, pe_n, cnt, k;
  bfb_flash_if bfb_flash_if_inst (.clock(clock), .nrst(nrst),
    .device_reset_n(device_reset_n), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .addr_valid_strobe_n(addr_valid_strobe_n), .bus_clk(bus_clk),
    .lockdown_guard_n(lockdown_guard_n), .addr(addr),
    .program_erase_permit(program_erase_permit), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .wait_out(wait_out),
    .wait_oe(wait_oe), .state_machine_flag_oe(state_machine_flag_oe),
    .arr_req(arr_req), .arr_addr(arr_addr), .arr_ack(arr_ack),
    .arr_data(arr_data), .pe_req(pe_req), .pe_erase(pe_erase),
    .pe_addr(pe_addr), .pe_data(pe_data), .wsm_busy(wsm_busy),
    .wsm_prog_done(wsm_prog_done), .wsm_erase_done(wsm_erase_done));
  bfb_far_model bfb_far_model_inst (.clock(clock), .nrst(nrst),
    .slow(slow), .arr_req(arr_req), .arr_addr(arr_addr),
    .arr_ack(arr_ack), .arr_data(arr_data), .pe_req(pe_req),
    .pe_erase(pe_erase), .wsm_busy(wsm_busy),
    .wsm_prog_done(wsm_prog_done), .wsm_erase_done(wsm_erase_done));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (pe_req === 1'b1) begin
      pe_n++;
      pe_a <= pe_addr;
      pe_d <= pe_data;
      pe_e <= pe_erase;
    end
  end
  function automatic logic [15:0] word_of(input logic [23:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction : word_of
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge clock);
    chip_enable_n = 1'b0;
    output_enable_n = 1'b1;
    addr = a;
    data_in = d;
    write_strobe_n = 1'b0;
    @(negedge clock);
    write_strobe_n = 1'b1;
    @(negedge clock);
  endtask : wr
  task automatic prog(input logic [23:0] a);
    int n0;
    n0 = pe_n;
    wr(a, 16'h0050);
    wr(a, 16'h0040);
    wr(a, 16'hBEEF);
    repeat (2) @(negedge clock);
    k = pe_n - n0;
    f = state_machine_flag_oe;
    repeat (14) @(negedge clock);
  endtask : prog
  task automatic rd(input logic [23:0] a);
    @(negedge clock);
    addr = a;
    chip_enable_n = 1'b0;
    output_enable_n = 1'b0;
    addr_valid_strobe_n = 1'b0;
    cnt = 0;
    while (data_out !== word_of(a) && cnt < 30) begin
      @(negedge clock);
      cnt++;
    end
    `CHK(data_out, word_of(a))
  endtask : rd
  task automatic t_pins();
    `CHK(data_oe, 1'b0)
    rd(24'h000100);
    `CHK(data_oe, 1'b1)
    `CHK(wait_oe, 1'b1)
    slow = 1'b1;
    rd(24'h000107);
    output_enable_n = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(data_oe, 1'b0)
    `CHK(wait_oe, 1'b1)
    chip_enable_n = 1'b1;
    repeat (2) @(negedge clock);
    `CHK({data_oe, wait_oe}, 2'b00)
    addr_valid_strobe_n = 1'b1;
    slow = 1'b0;
  endtask : t_pins
  task automatic t_prot();
    wr(24'h010000, 16'h0060);
    wr(24'h010000, 16'h00D0);
    prog(24'h010123);
    `CHK(k, 1)
    `CHK({pe_e, pe_a, pe_d}, {1'b0, 24'h010123, 16'hBEEF})
    `CHK(f, 1'b1)
    `CHK(state_machine_flag_oe, 1'b0)
    wr(24'h010040, 16'h0020);
    wr(24'h010040, 16'h00D0);
    repeat (2) @(negedge clock);
    `CHK(pe_e, 1'b1)
    repeat (14) @(negedge clock);
    program_erase_permit = 1'b0;
    prog(24'h010124);
    `CHK(k, 0)
    `CHK(data_out, 16'h0088)
    program_erase_permit = 1'b1;
    device_reset_n = 1'b0;
    prog(24'h010125);
    `CHK(k, 0)
    device_reset_n = 1'b1;
    wr(24'h010000, 16'h0060);
    wr(24'h010000, 16'h00D0);
    wr(24'h010000, 16'h0060);
    wr(24'h010000, 16'h002F);
    lockdown_guard_n = 1'b0;
    wr(24'h010000, 16'h0060);
    wr(24'h010000, 16'h00D0);
    prog(24'h010126);
    `CHK(k, 0)
    `CHK(data_out, 16'h0082)
    lockdown_guard_n = 1'b1;
    prog(24'h010127);
    `CHK(k, 1)
  endtask : t_prot
  task automatic t_pulse();
    wr(24'h000000, 16'h00B8);
    wr(24'h000000, 16'h0002);
    wr(24'h010128, 16'h0040);
    wr(24'h010128, 16'h1234);
    cnt = 0;
    repeat (50) begin
      @(negedge clock);
      cnt += (state_machine_flag_oe === 1'b1);
    end
    `CHK(cnt, 25)
  endtask : t_pulse
  task automatic t_burst();
    wr(24'h001042, 16'h0060);
    wr(24'h001042, 16'h0003);
    wr(24'h000000, 16'h00FF);
    chip_enable_n = 1'b1;
    @(negedge clock);
    chip_enable_n = 1'b0;
    output_enable_n = 1'b0;
    addr = 24'h000024;
    addr_valid_strobe_n = 1'b0;
    bus_clk = 1'b0;
    @(negedge clock);
    addr_valid_strobe_n = 1'b1;
    cnt = 0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clock);
      bus_clk = ~bus_clk;
      cnt += (wait_out === 1'b0);
      if (i > 2 && wait_out === 1'b1 && (q.size() == 0 ||
          data_out !== q[q.size()-1])) q.push_back(data_out);
    end
    `CHK(cnt != 0, 1'b1)
    `CHK(q[0], word_of(24'h000024))
    `CHK(q[4], word_of(24'h000020))
    `CHK(q[7], word_of(24'h000023))
    // Bus clock parks high between bursts, as an unused board would
    bus_clk = 1'b1;
    chip_enable_n = 1'b1;
  endtask : t_burst
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    print_verdict();
  end
  initial begin
    {nrst, device_reset_n, slow, pe_n, err_total, comparisons} = '0;
    {chip_enable_n, output_enable_n, write_strobe_n} = 3'b111;
    {addr_valid_strobe_n, bus_clk, lockdown_guard_n} = 3'b111;
    program_erase_permit = 1'b1;
    addr = 24'h000000;
    data_in = 16'h0000;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    device_reset_n = 1'b1;
    repeat (2) @(negedge clock);
    t_pins();
    t_prot();
    t_pulse();
    t_burst();
    print_verdict();
  end
endmodule : testbench
